// ==== src/cmx_pkg.sv ====
// Shared constants and carrier types for the comparator mux sequencer
package cmx_pkg;

  // Serial programming word layout
  localparam int unsigned MUX_BITS_4CH    = 3;
  localparam int unsigned MUX_BITS_2CH    = 2;
  localparam int unsigned THR_BITS        = 8;
  localparam int unsigned CNT_W           = 4;
  localparam int unsigned CH_COUNT_DEF    = 4;

  // Route vector layout: channels 0..3 then the common input
  localparam int unsigned ROUTE_POS_W     = 4;
  localparam int unsigned ROUTE_NEG_W     = 5;
  localparam int unsigned ROUTE_COM_BIT   = 4;

  // Reset values
  localparam logic [7:0]  THR_RST         = 8'h00;
  localparam logic [2:0]  MUX_RST         = 3'h0;
  localparam logic [3:0]  CNT_RST         = 4'h0;
  localparam logic [3:0]  POS_RST         = 4'h0;
  localparam logic [4:0]  NEG_RST         = 5'h00;
  localparam logic        OUT_RST         = 1'b0;

  typedef enum logic [1:0] {
    CMX_IDLE,
    CMX_ADDR,
    CMX_RUN
  } cmx_state_e;

  // Multiplexer assignment word as shifted in
  typedef struct packed {
    logic single_ended_flag;
    logic odd_sign;
    logic select;
  } cmx_cfg_s;

  // Analog switch routing derived from the assignment word
  typedef struct packed {
    logic [3:0] pos;
    logic [4:0] neg;
  } cmx_route_s;

endpackage

// ==== src/cmx_sequencer.sv ====
// Serial programming, mux routing and phase sequencing for a sampled-data comparator
`timescale 1ns/100ps

// What this block does
// R1 - Each comparison zeroes on the first input, then compares with the second.
// R2 - Positive input is sampled while clock high, negative while clock low.
// R3 - Result appears half a cycle after sampling; output changes only on falling edge.
// R4 - Positive input step reaches output within one to two clock cycles.
// R5 - Negative input step reaches output within half to one and a half cycles.
// R6 - Input change missing the pending decision shows one full cycle later.
// R7 - Channel, mode and polarity are fixed by addressing before comparing starts.
// R8 - The controller sends channel and polarity bits serially on serial_in.
// R9 - Differential pairs are only channels 0 with 1 and 2 with 3.
// R10 - Four-channel single-ended codes 00,01,10,11 pick channels 0,2,1,3 against common.
// R11 - Four-channel differential codes give 0+/1-, 2+/3-, 0-/1+, 2-/3+.
// R12 - Two-channel codes pick channel 0 or 1, or 0+/1- and 0-/1+.
// R13 - Two-channel common negative input is internally analog ground.
// R14 - Controller holds chip select low throughout and clocks data on rising edges.
// R15 - Leading zeros ignored; first one starts; mux bits then threshold LSB first.
// R16 - After last bit, serial_in ignored, output enabled, undefined for 1.5 cycles.
// R17 - Chip select high clears everything; new setup needs full reprogramming.
// R18 - While chip select high, output floats and shift logic stays idle.
// R19 - Once programmed, comparisons repeat every cycle until chip select rises.
module cmx_sequencer
  import cmx_pkg::*;
#(
  parameter int unsigned CHANNELS = CH_COUNT_DEF
) (
  // System
  input  wire logic              clk,
  input  wire logic              reset,
  // Serial link pins from the controller
  input  wire logic              cs_n_pin,
  input  wire logic              dev_clk_pin,
  input  wire logic              serial_in,
  // Decision from the analog comparator
  input  wire logic              cmp_in,
  // Serial result pin
  output logic                   data_out,
  output logic                   data_oe,
  // Analog switch and threshold control
  output logic [3:0]             pos_route,
  output logic [4:0]             neg_route,
  output logic                   pos_phase,
  output logic                   neg_phase,
  output logic [THR_BITS-1:0]    threshold_level,
  output logic                   single_ended_flag,
  output logic                   programmed
);

  localparam int unsigned MUX_BITS = (CHANNELS == 4) ? MUX_BITS_4CH : MUX_BITS_2CH;
  localparam int unsigned TOTAL    = MUX_BITS + THR_BITS;
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(TOTAL - 1);

  generate
    if (CHANNELS != 4 && CHANNELS != 2) begin : g_bad_channels
      $error("CHANNELS must be 2 or 4");
    end
  endgenerate

  // Pin synchronisers; stage one feeds stage two only
  logic       dclk_s1;
  logic       dclk_s2;
  logic       dclk_s3;
  logic       cs_n_s1;
  logic       cs_n_s2;
  logic       si_s1;
  logic       si_s2;
  logic       cmp_s1;
  logic       cmp_s2;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dclk_s1 <= 1'b0;
      dclk_s2 <= 1'b0;
      dclk_s3 <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      si_s1   <= 1'b0;
      si_s2   <= 1'b0;
      cmp_s1  <= 1'b0;
      cmp_s2  <= 1'b0;
    end else begin
      dclk_s1 <= dev_clk_pin;
      dclk_s2 <= dclk_s1;
      dclk_s3 <= dclk_s2;
      cs_n_s1 <= cs_n_pin;
      cs_n_s2 <= cs_n_s1;
      si_s1   <= serial_in;
      si_s2   <= si_s1;
      cmp_s1  <= cmp_in;
      cmp_s2  <= cmp_s1;
    end
  end

  logic dclk_rise;
  logic dclk_fall;

  assign dclk_rise = dclk_s2 & ~dclk_s3;
  assign dclk_fall = ~dclk_s2 & dclk_s3;

  // Map the assignment word onto the analog switches
  function automatic cmx_route_s decode_route(input cmx_cfg_s cfg, input logic four_ch);
    cmx_route_s r;
    logic       sel;
    r   = '{pos: POS_RST, neg: NEG_RST};
    sel = four_ch & cfg.select;
    if (cfg.single_ended_flag) begin
      // Odd/sign picks the odd channel; select picks the upper pair
      r.pos[{sel, cfg.odd_sign}] = 1'b1;                                        // [R10] [R12]
      // On the two-channel part this common leg is analog ground
      r.neg[ROUTE_COM_BIT]       = 1'b1;                                        // [R13]
    end else begin
      // Only adjacent pairs exist, so no other pairing can be decoded
      r.pos[{sel, cfg.odd_sign}]  = 1'b1;                                       // [R9] [R11]
      r.neg[{sel, ~cfg.odd_sign}] = 1'b1;                                       // [R9] [R11] [R12]
    end
    return r;
  endfunction

  // Programming and sequencing state
  cmx_state_e          state_reg;
  cmx_state_e          state_next;
  logic [CNT_W-1:0]    cnt_reg;
  logic [CNT_W-1:0]    cnt_next;
  logic [2:0]          mux_reg;
  logic [2:0]          mux_next;
  logic [THR_BITS-1:0] thr_reg;
  logic [THR_BITS-1:0] thr_next;
  logic                dec_reg;
  logic                dec_next;
  logic                dec_valid_reg;
  logic                dec_valid_next;
  logic                dout_reg;
  logic                dout_next;
  logic                oe_reg;
  logic                oe_next;
  cmx_route_s          route_reg;
  cmx_route_s          route_next;
  logic                pos_ph_reg;
  logic                pos_ph_next;
  logic                neg_ph_reg;
  logic                neg_ph_next;
  cmx_cfg_s            cfg;

  always_comb begin
    cfg = (CHANNELS == 4) ? cmx_cfg_s'(mux_reg) : cmx_cfg_s'({mux_reg[1:0], 1'b0});
  end

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    mux_next       = mux_reg;
    thr_next       = thr_reg;
    dec_next       = dec_reg;
    dec_valid_next = dec_valid_reg;
    dout_next      = dout_reg;
    oe_next        = oe_reg;
    route_next     = route_reg;
    case (state_reg)
      CMX_IDLE: begin
        if (dclk_rise && si_s2) begin                                           // [R15]
          state_next = CMX_ADDR;
          cnt_next   = CNT_RST;
        end
      end
      CMX_ADDR: begin
        if (dclk_rise) begin
          if (cnt_reg < CNT_W'(MUX_BITS)) begin
            mux_next = {mux_reg[1:0], si_s2};                                   // [R8] [R15]
          end else begin
            thr_next = {si_s2, thr_reg[THR_BITS-1:1]};                          // [R15]
          end
          cnt_next = cnt_reg + CNT_W'(1);
          if (cnt_reg == LAST_BIT) begin
            // Last bit taken: serial_in is ignored from here on
            state_next = CMX_RUN;                                               // [R16]
            oe_next    = 1'b1;                                                  // [R16]
          end
        end
      end
      CMX_RUN: begin
        // Routing is decoded again every run cycle from the frozen word, so it holds while selected
        route_next = decode_route(cfg, CHANNELS == 4);                          // [R7] [R19]
        // Decision is strobed at the end of the low (negative) half period
        if (dclk_rise) begin
          dec_next       = cmp_s2;                                              // [R4] [R5] [R6]
          dec_valid_next = 1'b1;
        end
        // Leaving the output alone until a decision exists gives the undefined 1.5 cycles
        if (dclk_fall && dec_valid_reg) begin
          dout_next = dec_reg;                                                  // [R3] [R16]
        end
      end
      default: begin
        state_next = CMX_IDLE;
      end
    endcase
    // Chip select high overrides everything and wipes all programming
    if (cs_n_s2) begin                                                          // [R17] [R18]
      state_next     = CMX_IDLE;
      cnt_next       = CNT_RST;
      mux_next       = MUX_RST;
      thr_next       = THR_RST;
      dec_next       = OUT_RST;
      dec_valid_next = 1'b0;
      dout_next      = OUT_RST;
      oe_next        = 1'b0;
      route_next     = '{pos: POS_RST, neg: NEG_RST};
    end
  end

  // Phase switches follow the device clock only while comparing
  always_comb begin
    pos_ph_next = (state_next == CMX_RUN) && dclk_s2;                           // [R1] [R2]
    neg_ph_next = (state_next == CMX_RUN) && !dclk_s2;                          // [R1] [R2]
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg     <= CMX_IDLE;
      cnt_reg       <= CNT_RST;
      mux_reg       <= MUX_RST;
      thr_reg       <= THR_RST;
      dec_reg       <= OUT_RST;
      dec_valid_reg <= 1'b0;
      dout_reg      <= OUT_RST;
      oe_reg        <= 1'b0;
      route_reg     <= '{pos: POS_RST, neg: NEG_RST};
      pos_ph_reg    <= 1'b0;
      neg_ph_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      mux_reg       <= mux_next;
      thr_reg       <= thr_next;
      dec_reg       <= dec_next;
      dec_valid_reg <= dec_valid_next;
      dout_reg      <= dout_next;
      oe_reg        <= oe_next;
      route_reg     <= route_next;
      pos_ph_reg    <= pos_ph_next;
      neg_ph_reg    <= neg_ph_next;
    end
  end

  assign data_out          = dout_reg;
  assign data_oe           = oe_reg;
  assign pos_route         = route_reg.pos;
  assign neg_route         = route_reg.neg;
  assign pos_phase         = pos_ph_reg;
  assign neg_phase         = neg_ph_reg;
  assign threshold_level   = thr_reg;
  assign single_ended_flag = mux_reg[MUX_BITS-1];
  assign programmed        = oe_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_phase_exclusive;
    !(pos_ph_reg && neg_ph_reg);
  endproperty
  a_phase_exclusive: assert property (p_phase_exclusive)                        // [R1]
    else $error("zeroing and compare phases overlap");

  property p_phase_tracks_clk;
    (state_reg == CMX_RUN && !cs_n_s2)
      |=> (pos_ph_reg == $past(dclk_s2)) && (neg_ph_reg != $past(dclk_s2));
  endproperty
  a_phase_tracks_clk: assert property (p_phase_tracks_clk)                      // [R2]
    else $error("sampling phase does not follow device clock level");

  property p_out_on_fall;
    $changed(dout_reg) && !$past(cs_n_s2) |-> $past(dclk_fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall)                                // [R3]
    else $error("result changed away from a falling clock edge");

  property p_decision_capture;
    (state_reg == CMX_RUN && dclk_rise && !cs_n_s2) |=> dec_reg == $past(cmp_s2) && dec_valid_reg;
  endproperty
  a_decision_capture: assert property (p_decision_capture)                      // [R4]
    else $error("decision not captured at end of clock period");

  property p_oe_at_last_bit;
    $rose(oe_reg) |-> $past(state_reg == CMX_ADDR && dclk_rise && cnt_reg == LAST_BIT);
  endproperty
  a_oe_at_last_bit: assert property (p_oe_at_last_bit)                          // [R16]
    else $error("output enabled at the wrong bit");

  property p_cs_clears;
    cs_n_s2 |=> !oe_reg && state_reg == CMX_IDLE && thr_reg == THR_RST && !pos_ph_reg;
  endproperty
  a_cs_clears: assert property (p_cs_clears)                                    // [R17]
    else $error("chip select high did not clear the block");

  property p_leading_zero;
    (state_reg == CMX_IDLE && !cs_n_s2 && !(dclk_rise && si_s2)) |=> state_reg == CMX_IDLE;
  endproperty
  a_leading_zero: assert property (p_leading_zero)                              // [R15]
    else $error("left idle without a start bit");

  property p_setup_frozen;
    (state_reg == CMX_RUN && !cs_n_s2) |=> $stable(thr_reg) && $stable(mux_reg);
  endproperty
  a_setup_frozen: assert property (p_setup_frozen)                              // [R19]
    else $error("setup changed while comparing");

  property p_adjacent_pair;
    (state_reg == CMX_RUN && !single_ended_flag && route_reg.pos != POS_RST)
      |-> ((route_reg.pos | route_reg.neg[3:0]) == 4'h3)
          || ((route_reg.pos | route_reg.neg[3:0]) == 4'hc);
  endproperty
  a_adjacent_pair: assert property (p_adjacent_pair)                            // [R9]
    else $error("differential pair is not adjacent");

  cover property (state_reg == CMX_ADDR ##1 state_reg == CMX_RUN);
  cover property (state_reg == CMX_RUN && $rose(dout_reg));
  cover property (state_reg == CMX_ADDR && cs_n_s2);

endmodule

// ==== bench/cmx_ctrl_model.sv ====
// Controller model: free-running device clock, chip select and serial word
`timescale 1ns/100ps
module cmx_ctrl_model
  import cmx_pkg::*;
#(
  parameter int unsigned HALF = 4
) (
  // System
  input  wire logic        clk,
  input  wire logic        reset,
  // Requests from the bench
  input  wire logic        load,
  input  wire logic        rel,
  input  wire logic [15:0] word,
  input  wire logic [4:0]  nbits,
  // Pins toward the block
  output logic             cs_n_pin,
  output logic             dev_clk_pin,
  output logic             serial_in
);
  logic [7:0] div;
  logic [4:0] left;
  logic       pend;
  logic       rel_pend;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div <= 8'h00;
      left <= 5'h00;
      pend <= 1'b0;
      rel_pend <= 1'b0;
      cs_n_pin <= 1'b1;
      dev_clk_pin <= 1'b0;
      serial_in <= 1'b0;
    end else begin
      if (div == 8'(HALF - 1)) begin
        div <= 8'h00;
        dev_clk_pin <= ~dev_clk_pin;
        // Data moves only at falling edges, so it is stable across each rise
        if (dev_clk_pin) begin
          if (rel_pend) begin
            cs_n_pin <= 1'b1;
            rel_pend <= 1'b0;
            left <= 5'h00;
            serial_in <= ~serial_in;
          end else if (pend) begin
            cs_n_pin <= 1'b0;
            pend <= 1'b0;
            serial_in <= word[nbits - 5'h01];
            left <= nbits - 5'h01;
          end else if (left != 5'h00) begin
            serial_in <= word[left - 5'h01];
            left <= left - 5'h01;
          end else begin
            // Line no longer holds data: toggle so stale values never look valid
            serial_in <= ~serial_in;
          end
        end
      end else begin
        div <= div + 8'h01;
      end
      if (load) begin
        pend <= 1'b1;
      end
      if (rel) begin
        rel_pend <= 1'b1;
      end
    end
  end
endmodule

// ==== bench/cmx_sequencer_tb_top.sv ====
// Self-checking bench for the sequencer, both channel variants
`timescale 1ns/100ps
module cmx_sequencer_tb_top
  import cmx_pkg::*;
;
  logic clk, reset, load, rel, cmp_in, cs_n_pin, dev_clk_pin, serial_in;
  logic [15:0] word;
  logic [4:0]  nbits;
  logic        d_out, oe, pph, nph, se, prog, d_out_b, oe_b, pph_b, nph_b, se_b, prog_b;
  logic [3:0]  pos, pos_b;
  logic [4:0]  neg, neg_b;
  logic [7:0]  thr, thr_b;
  int          n_mismatch, checks, cycles;
  logic [15:0] idle_a, idle_b;

  // Every output but the threshold that must read zero while deselected, one word per variant
  assign idle_a = 16'({oe, d_out, prog, se, pph, nph, pos, neg});
  assign idle_b = 16'({oe_b, d_out_b, prog_b, se_b, pph_b, nph_b, pos_b, neg_b});

  cmx_ctrl_model #(.HALF(4)) ctrl (.clk(clk), .reset(reset), .load(load), .rel(rel),
    .word(word), .nbits(nbits), .cs_n_pin(cs_n_pin), .dev_clk_pin(dev_clk_pin),
    .serial_in(serial_in));
  cmx_sequencer #(.CHANNELS(4)) DUT (.clk(clk), .reset(reset), .cs_n_pin(cs_n_pin),
    .dev_clk_pin(dev_clk_pin), .serial_in(serial_in), .cmp_in(cmp_in), .data_out(d_out),
    .data_oe(oe), .pos_route(pos), .neg_route(neg), .pos_phase(pph), .neg_phase(nph),
    .threshold_level(thr), .single_ended_flag(se), .programmed(prog));
  cmx_sequencer #(.CHANNELS(2)) DUT_2ch (.clk(clk), .reset(reset), .cs_n_pin(cs_n_pin),
    .dev_clk_pin(dev_clk_pin), .serial_in(serial_in), .cmp_in(cmp_in),
    .data_out(d_out_b), .data_oe(oe_b), .pos_route(pos_b), .neg_route(neg_b),
    .pos_phase(pph_b), .neg_phase(nph_b), .threshold_level(thr_b),
    .single_ended_flag(se_b), .programmed(prog_b));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  // Start bit, mux bits, then threshold least significant bit first
  function automatic logic [15:0] mk(input logic [3:0] mux, input logic [7:0] t);
    logic [15:0] w;
    w = {12'h000, mux};
    for (int i = 0; i < 8; i++) w = {w[14:0], t[i]};
    return w;
  endfunction

  // Routes written out from the channel tables, not from an index formula
  function automatic cmx_route_s exp_route(input logic s, input logic odd, input logic sel);
    cmx_route_s r;
    case ({s, odd, sel})
      3'b100:  r = '{pos: 4'h1, neg: 5'h10};
      3'b101:  r = '{pos: 4'h4, neg: 5'h10};
      3'b110:  r = '{pos: 4'h2, neg: 5'h10};
      3'b111:  r = '{pos: 4'h8, neg: 5'h10};
      3'b000:  r = '{pos: 4'h1, neg: 5'h02};
      3'b001:  r = '{pos: 4'h4, neg: 5'h08};
      3'b010:  r = '{pos: 4'h2, neg: 5'h01};
      default: r = '{pos: 4'h8, neg: 5'h04};
    endcase
    return r;
  endfunction

  task automatic send_setup(input logic [15:0] w, input logic [4:0] n, input bit two);
    int k;
    word <= w;
    nbits <= n;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    k = 0;
    while ((two ? oe_b : oe) !== 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    check(16'(k < 400), 16'h1, "output enable after programming");
    // Routing registers a cycle after the enable; let it settle before callers look
    repeat (2) @(posedge clk);
  endtask

  task automatic release_cs();
    rel <= 1'b1;
    @(posedge clk);
    rel <= 1'b0;
    repeat (24) @(posedge clk);
    check(idle_a, 16'h0000, "idle outputs");
    check(idle_b, 16'h0000, "idle outputs 2ch");
    check({thr, thr_b}, 16'h0000, "thresholds cleared");
  endtask

  task automatic t_codes4();
    logic [7:0] t;
    for (int c = 0; c < 8; c++) begin
      t = {c[2:0], 5'h13};
      send_setup(mk({1'b1, c[2:0]}, t), 5'd12, 1'b0);
      if (c[2]) check(16'({pos, neg}), 16'(exp_route(1'b1, c[1], c[0])), "route se");
      else check(16'({pos, neg}), 16'(exp_route(1'b0, c[1], c[0])), "route diff");
      check({7'h00, se, thr}, {7'h00, c[2], t}, "mode and threshold");
      release_cs();
    end
    $display("test codes4 done");
  endtask

  task automatic t_codes2();
    for (int c = 0; c < 4; c++) begin
      send_setup(mk({2'b01, c[1], c[0]}, {c[0], 7'h2d}), 5'd11, 1'b1);
      check(16'({pos_b, neg_b}), 16'(exp_route(c[1], c[0], 1'b0)), "route 2ch");
      check({7'h00, se_b, thr_b}, {7'h00, c[1], c[0], 7'h2d}, "2ch threshold");
      release_cs();
    end
    $display("test codes2 done");
  endtask

  task automatic t_compare();
    logic [4:0] v;
    int         hi, lo, both, lat;
    v = 5'b10110;
    hi = 0;
    lo = 0;
    both = 0;
    // Three leading zeros before the start bit
    send_setup(mk(4'b1111, 8'ha7), 5'd15, 1'b0);
    for (int i = 0; i < 5; i++) begin
      cmp_in <= v[i];
      lat = -1;
      for (int n = 0; n < 40; n++) begin
        @(posedge clk);
        hi += int'(pph);
        lo += int'(nph);
        both += int'(pph & nph);
        if (lat < 0 && d_out === v[i]) lat = n;
      end
      check({14'h0000, d_out_b, d_out}, {14'h0000, v[i], v[i]}, "decision");
      // Two device clock periods of eight cycles, plus pin synchroniser latency
      check(16'(lat >= 0 && lat <= 20), 16'h1, "decision latency");
      check({pos, neg, thr[6:0]}, {4'h8, 5'h10, 7'h27}, "setup kept");
      check(16'({pos_b, neg_b, se_b}), 16'({4'h2, 5'h10, 1'b1}), "2ch setup");
    end
    check(16'(hi > 0 && lo > 0 && both == 0), 16'h1, "phases");
    release_cs();
    $display("test compare done");
  endtask

  task automatic t_abort();
    word <= mk(4'b1001, 8'hff);
    nbits <= 5'd12;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    repeat (50) @(posedge clk);
    release_cs();
    send_setup(mk(4'b1010, 8'h3c), 5'd12, 1'b0);
    check({8'h00, thr}, 16'h003c, "reprogrammed");
    check(16'({pos, neg}), 16'(exp_route(1'b0, 1'b1, 1'b0)), "route after abort");
    release_cs();
    $display("test abort done");
  endtask

  initial begin
    reset = 1'b1;
    load = 1'b0;
    rel = 1'b0;
    cmp_in = 1'b0;
    word = 16'h0000;
    nbits = 5'h00;
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    check(idle_a, 16'h0000, "after reset");
    check(idle_b, 16'h0000, "after reset 2ch");
    $display("test reset done");
    t_codes4();
    t_codes2();
    t_compare();
    t_abort();
    summarize();
  end
endmodule
